/* File: inc/nic_cfg.svh */
`ifndef NIC_CFG_SVH
`define NIC_CFG_SVH

// Register addresses on the special function bus
`define NIC_ADDR_EN_MAIN    8'ha8
`define NIC_ADDR_PRI_MAIN   8'hb8
`define NIC_ADDR_FLAGS      8'hc0
`define NIC_ADDR_EN_PORT    8'he8
`define NIC_ADDR_POL_PORT   8'he9
`define NIC_ADDR_PRI_PORT   8'hf8

// Bit positions in the main enable and priority registers, global in the enable register only
`define NIC_BIT_GLOBAL      7
`define NIC_BIT_SERIAL      5
`define NIC_BIT_TIMER1      3
`define NIC_BIT_EXT1        2
`define NIC_BIT_TIMER0      1
`define NIC_BIT_EXT0        0

// Implemented bits, unused ones read as zero
`define NIC_EN_MAIN_MASK    8'haf
`define NIC_PRI_MAIN_MASK   8'h2f

// Reset values
`define NIC_RST_EN_MAIN     8'h00
`define NIC_RST_PRI_MAIN    8'h00
`define NIC_RST_EN_PORT     8'h00
`define NIC_RST_POL_PORT    8'h00
`define NIC_RST_PRI_PORT    8'h00
`define NIC_RST_FLAGS       8'h00

// Vector index per slot, slot 12 first, slot 0 highest in order
`define NIC_VEC_TABLE       52'he9d83c72b1a50
`define NIC_VEC_BASE        16'h0003
`define NIC_VEC_STEP_SHIFT  3
`define NIC_NUM_SRC         13

`endif

/* File: inc/nic_pkg.sv */
package nic_pkg;

  // Service level held by the nesting tracker, Gray along the path
  typedef enum logic [1:0] {
    NIC_ST_NONE = 2'b00,
    NIC_ST_LOW  = 2'b01,
    NIC_ST_BOTH = 2'b11,
    NIC_ST_HIGH = 2'b10
  } nic_state_t;

  typedef logic [3:0] nic_vec_t;

endpackage

/* File: verilog/nic_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module nic_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // Pins and synchronised copy
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_pin_sync;

  // First stage feeds only the second
  always_comb begin
    next_stage1   = pin_in;
    next_pin_sync = stage1;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stage1   <= '0;
      pin_sync <= '0;
    end else begin
      stage1   <= next_stage1;
      pin_sync <= next_pin_sync;
    end
  end

endmodule // nic_sync

`default_nettype wire

/* File: verilog/nic_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "nic_cfg.svh"

module nic_ctrl
  import nic_pkg::*;
#(
  parameter int NPORT = 8
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // Special function register port
  input  wire logic [7:0]       sfr_addr,
  input  wire logic             sfr_wr,
  input  wire logic             sfr_rd,
  input  wire logic [7:0]       sfr_wdata,
  output logic      [7:0]       sfr_rdata,
  // Source requests on the same clock
  input  wire logic             ext0_req,
  input  wire logic             ext1_req,
  input  wire logic             timer0_req,
  input  wire logic             timer1_req,
  input  wire logic             serial_req,
  // Port pins, asynchronous
  input  wire logic [NPORT-1:0] port_ext_inputs,
  // CPU vectoring
  input  wire logic             irq_ack,
  input  wire logic             irq_return,
  output logic                  irq_req,
  output logic                  irq_level,
  output nic_vec_t              irq_vector_index,
  output logic      [15:0]      irq_vector_addr,
  // Power-down wake
  output logic                  wake
);

  logic [7:0]       irq_enable_main;
  logic [7:0]       irq_priority_main;
  logic [7:0]       irq_enable_port_ext;
  logic [7:0]       irq_polarity_port_ext;
  logic [7:0]       irq_priority_port_ext;
  logic [7:0]       port_ext_request_flags;
  logic [7:0]       next_en_main;
  logic [7:0]       next_pri_main;
  logic [7:0]       next_en_port;
  logic [7:0]       next_pol_port;
  logic [7:0]       next_pri_port;
  logic [7:0]       next_flags;
  logic [7:0]       next_rdata;
  logic [NPORT-1:0] pin_sync;
  logic [NPORT-1:0] active;
  logic [NPORT-1:0] active_prev;
  logic [NPORT-1:0] act_rise;
  logic [NPORT-1:0] flag_set;
  logic [`NIC_NUM_SRC-1:0] src_pend;
  logic [`NIC_NUM_SRC-1:0] src_en;
  logic [`NIC_NUM_SRC-1:0] src_pri;
  logic [`NIC_NUM_SRC-1:0] eff_high;
  logic [`NIC_NUM_SRC-1:0] eff_low;
  logic [51:0]      vec_table;
  nic_state_t       state;
  nic_state_t       next_state;
  logic             next_req;
  logic             next_level;
  nic_vec_t         next_vec;
  logic [15:0]      next_addr;
  logic             next_wake;
  logic             wr_en_main;
  logic             wr_pri_main;
  logic             wr_en_port;
  logic             wr_pol_port;
  logic             wr_pri_port;
  logic             wr_flags;
  logic             taken;

  assign vec_table = `NIC_VEC_TABLE;

  nic_sync #(
    .WIDTH (NPORT)
  ) u_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .pin_in   (port_ext_inputs),
    .pin_sync (pin_sync)
  );

  assign active   = (pin_sync & irq_polarity_port_ext)
                  | (~pin_sync & ~irq_polarity_port_ext);
  assign act_rise = active & ~active_prev;
  assign flag_set = act_rise & irq_enable_port_ext;

  // Register decode
  assign wr_en_main  = sfr_wr && (sfr_addr == `NIC_ADDR_EN_MAIN);
  assign wr_pri_main = sfr_wr && (sfr_addr == `NIC_ADDR_PRI_MAIN);
  assign wr_en_port  = sfr_wr && (sfr_addr == `NIC_ADDR_EN_PORT);
  assign wr_pol_port = sfr_wr && (sfr_addr == `NIC_ADDR_POL_PORT);
  assign wr_pri_port = sfr_wr && (sfr_addr == `NIC_ADDR_PRI_PORT);
  assign wr_flags    = sfr_wr && (sfr_addr == `NIC_ADDR_FLAGS);

  always_comb begin
    next_en_main  = wr_en_main ? (sfr_wdata & `NIC_EN_MAIN_MASK)
                               : irq_enable_main;
    next_pri_main = wr_pri_main ? (sfr_wdata & `NIC_PRI_MAIN_MASK)
                                : irq_priority_main;
    next_en_port  = wr_en_port ? sfr_wdata : irq_enable_port_ext;
    next_pol_port = wr_pol_port ? sfr_wdata : irq_polarity_port_ext;
    next_pri_port = wr_pri_port ? sfr_wdata : irq_priority_port_ext;
    next_flags    = (wr_flags ? sfr_wdata : port_ext_request_flags)
                  | flag_set;
    case (sfr_addr)
      `NIC_ADDR_EN_MAIN:  next_rdata = irq_enable_main;
      `NIC_ADDR_PRI_MAIN: next_rdata = irq_priority_main;
      `NIC_ADDR_EN_PORT:  next_rdata = irq_enable_port_ext;
      `NIC_ADDR_POL_PORT: next_rdata = irq_polarity_port_ext;
      `NIC_ADDR_PRI_PORT: next_rdata = irq_priority_port_ext;
      `NIC_ADDR_FLAGS:    next_rdata = port_ext_request_flags;
      default:            next_rdata = 8'h00;
    endcase
    if (!sfr_rd) begin
      next_rdata = 8'h00;
    end
    next_wake = |(active & irq_enable_port_ext);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_enable_main        <= `NIC_RST_EN_MAIN;
      irq_priority_main      <= `NIC_RST_PRI_MAIN;
      irq_enable_port_ext    <= `NIC_RST_EN_PORT;
      irq_polarity_port_ext  <= `NIC_RST_POL_PORT;
      irq_priority_port_ext  <= `NIC_RST_PRI_PORT;
      port_ext_request_flags <= `NIC_RST_FLAGS;
      sfr_rdata              <= 8'h00;
      active_prev            <= '1;  // No false edge out of reset
      wake                   <= 1'b0;
    end else begin
      irq_enable_main        <= next_en_main;
      irq_priority_main      <= next_pri_main;
      irq_enable_port_ext    <= next_en_port;
      irq_polarity_port_ext  <= next_pol_port;
      irq_priority_port_ext  <= next_pri_port;
      port_ext_request_flags <= next_flags;
      sfr_rdata              <= next_rdata;
      active_prev            <= active;
      wake                   <= next_wake;
    end
  end

  assign src_pend = {port_ext_request_flags[7], port_ext_request_flags[2],
                     port_ext_request_flags[6], port_ext_request_flags[1],
                     timer1_req, port_ext_request_flags[5],
                     port_ext_request_flags[0], ext1_req,
                     port_ext_request_flags[4], timer0_req,
                     port_ext_request_flags[3], serial_req, ext0_req};
  assign src_en   = {irq_enable_port_ext[7], irq_enable_port_ext[2],
                     irq_enable_port_ext[6], irq_enable_port_ext[1],
                     irq_enable_main[`NIC_BIT_TIMER1],
                     irq_enable_port_ext[5], irq_enable_port_ext[0],
                     irq_enable_main[`NIC_BIT_EXT1],
                     irq_enable_port_ext[4],
                     irq_enable_main[`NIC_BIT_TIMER0],
                     irq_enable_port_ext[3],
                     irq_enable_main[`NIC_BIT_SERIAL],
                     irq_enable_main[`NIC_BIT_EXT0]};
  assign src_pri  = {irq_priority_port_ext[7], irq_priority_port_ext[2],
                     irq_priority_port_ext[6], irq_priority_port_ext[1],
                     irq_priority_main[`NIC_BIT_TIMER1],
                     irq_priority_port_ext[5], irq_priority_port_ext[0],
                     irq_priority_main[`NIC_BIT_EXT1],
                     irq_priority_port_ext[4],
                     irq_priority_main[`NIC_BIT_TIMER0],
                     irq_priority_port_ext[3],
                     irq_priority_main[`NIC_BIT_SERIAL],
                     irq_priority_main[`NIC_BIT_EXT0]};

  assign eff_high = src_pend & src_en & src_pri
                  & {`NIC_NUM_SRC{irq_enable_main[`NIC_BIT_GLOBAL]}};
  assign eff_low  = src_pend & src_en & ~src_pri
                  & {`NIC_NUM_SRC{irq_enable_main[`NIC_BIT_GLOBAL]}};

  assign taken = irq_ack && irq_req;

  always_comb begin
    next_state = state;
    case (state)
      NIC_ST_NONE: begin
        if (taken) begin
          next_state = irq_level ? NIC_ST_HIGH : NIC_ST_LOW;
        end
      end
      NIC_ST_LOW: begin
        if (taken && irq_level) begin
          next_state = irq_return ? NIC_ST_HIGH : NIC_ST_BOTH;
        end else if (irq_return) begin
          next_state = NIC_ST_NONE;
        end
      end
      NIC_ST_BOTH: begin
        if (irq_return) begin
          next_state = NIC_ST_LOW;
        end
      end
      NIC_ST_HIGH: begin
        if (irq_return) begin
          next_state = NIC_ST_NONE;
        end
      end
      default: next_state = NIC_ST_NONE;
    endcase
  end

  always_comb begin
    next_req   = 1'b0;
    next_level = 1'b0;
    next_vec   = 4'h0;
    // First slot in fixed order wins
    // High only over none or low
    if (!taken && (|eff_high) &&
        (state == NIC_ST_NONE || state == NIC_ST_LOW)) begin
      next_req   = 1'b1;
      next_level = 1'b1;
      for (int i = `NIC_NUM_SRC - 1; i >= 0; i--) begin
        if (eff_high[i]) begin
          next_vec = vec_table[i*4 +: 4];
        end
      end
    end else if (!taken && (|eff_low) && state == NIC_ST_NONE) begin
      next_req = 1'b1;
      for (int i = `NIC_NUM_SRC - 1; i >= 0; i--) begin
        if (eff_low[i]) begin
          next_vec = vec_table[i*4 +: 4];
        end
      end
    end
    next_addr = `NIC_VEC_BASE
              + {9'h000, next_vec, 3'b000};
  end

  // Outputs drop to vector 0 and the base address while idle, req says if it is live
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state            <= NIC_ST_NONE;
      irq_req          <= 1'b0;
      irq_level        <= 1'b0;
      irq_vector_index <= 4'h0;
      irq_vector_addr  <= `NIC_VEC_BASE;
    end else begin
      state            <= next_state;
      irq_req          <= next_req;
      irq_level        <= next_level;
      irq_vector_index <= next_vec;
      irq_vector_addr  <= next_addr;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  glob_gate_a: assert property (
    !irq_enable_main[`NIC_BIT_GLOBAL] |=> !irq_req)
    else $error("request while global enable off");
  src_enabled_a: assert property (
    irq_req |-> ($past(src_en) != '0))
    else $error("request with no source enabled");
  vec_addr_a: assert property (
    irq_req |-> irq_vector_addr == 16'h0003 + {9'h000, irq_vector_index,
                                               3'b000})
    else $error("vector address mismatch");
  high_block_a: assert property (
    (state == NIC_ST_HIGH || state == NIC_ST_BOTH) |=> !irq_req)
    else $error("request during high service");
  low_wait_a: assert property (
    (state == NIC_ST_LOW && irq_req) |-> irq_level)
    else $error("low request nested into low");
  flag_hold_a: assert property (
    !wr_flags |=> (port_ext_request_flags & $past(port_ext_request_flags))
                  == $past(port_ext_request_flags))
    else $error("flag cleared by hardware");
  flag_set_a: assert property (
    (|flag_set) |=> (port_ext_request_flags & $past(flag_set))
                    == $past(flag_set))
    else $error("flag not set on activation");
  wake_a: assert property (
    (|(active & irq_enable_port_ext)) |=> wake)
    else $error("no wake on enabled active pin");
  order_a: assert property (
    (irq_req && !irq_level) |-> $past(eff_high) == '0 ||
                                $past(state) != NIC_ST_NONE)
    else $error("low presented over high");

  high_ack_c: cover property (taken && irq_level);
  preempt_c:  cover property (state == NIC_ST_BOTH);
  wake_c:     cover property (wake);
  flag_clr_c: cover property (wr_flags && port_ext_request_flags != 8'h00);

endmodule // nic_ctrl

`default_nettype wire

/* File: verif/nic_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none

module nic_cpu_model
  import nic_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Pacing set by the bench
  input  wire logic [7:0]  ack_dly,
  input  wire logic [7:0]  svc_len,
  // Vector interface
  input  wire logic        irq_req,
  input  wire logic        irq_level,
  input  wire nic_vec_t    irq_vector_index,
  input  wire logic [15:0] irq_vector_addr,
  output logic             irq_ack,
  output logic             irq_return,
  // Last vector taken
  output logic             taken,
  output nic_vec_t         tk_idx,
  output logic             tk_lvl,
  output logic [15:0]      tk_addr
);
  int wait_cnt;
  int svc[$];

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_ack    <= 1'b0;
      irq_return <= 1'b0;
      taken      <= 1'b0;
      tk_idx     <= 4'h0;
      tk_lvl     <= 1'b0;
      tk_addr    <= 16'h0000;
      wait_cnt = 0;
      svc.delete();
    end else begin
      irq_ack    <= 1'b0;
      irq_return <= 1'b0;
      taken      <= 1'b0;
      wait_cnt = irq_req ? wait_cnt + 1 : 0;
      if (irq_ack) begin
        // Vector still presented at the edge that takes the ack
        taken   <= 1'b1;
        tk_idx  <= irq_vector_index;
        tk_lvl  <= irq_level;
        tk_addr <= irq_vector_addr;
        svc.push_back(int'(svc_len));
        wait_cnt = 0;
      end else if (irq_req && wait_cnt > int'(ack_dly)) begin
        irq_ack <= 1'b1;
      end else if (svc.size() > 0) begin
        // Only the innermost routine runs, outer ones are pre-empted
        svc[$] = svc[$] - 1;
        if (svc[$] <= 0) begin
          irq_return <= 1'b1;
          void'(svc.pop_back());
        end
      end
    end
  end
endmodule // nic_cpu_model

`default_nettype wire

/* File: verif/two_level_nested_interrupt_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module two_level_nested_interrupt_ctrl_tb import nic_pkg::*;;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  sfr_addr = 8'h00;
  logic        sfr_wr = 1'b0;
  logic        sfr_rd = 1'b0;
  logic [7:0]  sfr_wdata = 8'h00;
  logic [7:0]  sfr_rdata;
  logic [5:0]  src = 6'h00;
  logic [7:0]  pins = 8'h00;
  logic [7:0]  ack_dly = 8'h00;
  logic [7:0]  svc_len = 8'h06;
  logic        irq_ack, irq_return, irq_req, irq_level, wake;
  logic        taken, tk_lvl;
  nic_vec_t    irq_vector_index, tk_idx;
  logic [15:0] irq_vector_addr, tk_addr;
  logic [7:0]  rd;
  int          err_total = 0;
  int          comparisons = 0;
  int          seed = 75111;
  int          flg = 0;
  int          hi = 0;
  int          expq[$];
  int ord[13] = '{0, 5, 10, 1, 11, 2, 7, 12, 3, 8, 13, 9, 14};
  int adr[7] = '{8'ha8, 8'hb8, 8'he9, 8'hf8, 8'hc0, 8'he8, 8'h55};
  int msk[7] = '{8'haf, 8'h2f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00};

  always #2.5 clock = ~clock;

  nic_ctrl #(.NPORT(8)) dut (
    .clock(clock), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .ext0_req(src[0]), .ext1_req(src[2]), .timer0_req(src[1]),
    .timer1_req(src[3]), .serial_req(src[5]), .port_ext_inputs(pins),
    .irq_ack(irq_ack), .irq_return(irq_return), .irq_req(irq_req),
    .irq_level(irq_level), .irq_vector_index(irq_vector_index),
    .irq_vector_addr(irq_vector_addr), .wake(wake));

  nic_cpu_model cpu (
    .clock(clock), .rst_n(rst_n), .ack_dly(ack_dly), .svc_len(svc_len),
    .irq_req(irq_req), .irq_level(irq_level),
    .irq_vector_index(irq_vector_index), .irq_vector_addr(irq_vector_addr),
    .irq_ack(irq_ack), .irq_return(irq_return), .taken(taken),
    .tk_idx(tk_idx), .tk_lvl(tk_lvl), .tk_addr(tk_addr));

  task automatic finish_test();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge clock);
    sfr_wr    <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge clock);
    sfr_rd   <= 1'b0;
    #1 chk(16'(sfr_rdata), 16'(e));
  endtask

  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge clock);
      chk(16'(irq_req), 16'h0000);
    end
  endtask

  // Waits for the next vector taken and clears its source
  task automatic take_one();
    int e;
    int i;
    e = expq.pop_front();
    for (i = 0; i < 400; i++) begin
      @(posedge clock);
      if (taken === 1'b1)
        break;
    end
    if (taken !== 1'b1) begin
      chk(16'(taken), 16'h0001);
      finish_test();
    end else begin
      chk(16'(tk_idx), 16'(e));
      chk(tk_addr, 16'(3 + 8 * e));
      chk(16'(tk_lvl), 16'((hi >> e) & 1));
      if (e < 7) begin
        src[e] <= 1'b0;
      end else begin
        flg = flg & ~(1 << (e - 7));
        wr(8'hc0, 8'(flg));
      end
    end
  endtask

  initial begin
    int i;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    for (i = 0; i < 7; i++) rdchk(8'(adr[i]), 8'h00);
    for (i = 0; i < 7; i++) begin
      // Global bit kept off so random enables cannot start service
      rd = 8'($random(seed)) & ((i == 0) ? 8'h7f : 8'hff);
      wr(8'(adr[i]), rd);
      rdchk(8'(adr[i]), rd & 8'(msk[i]));
    end
    // Reverse order: port enable clears before the flags, so no flag is left behind
    for (i = 6; i >= 0; i--) wr(8'(adr[i]), 8'h00);
    rdchk(8'hc0, 8'h00);
    $display("test registers done");
    wr(8'he9, 8'hff);
    wr(8'he8, 8'hff);
    wr(8'ha8, 8'h2f);
    @(posedge clock);
    src  <= 6'h2f;
    pins <= 8'hff;
    quiet(8);
    rdchk(8'hc0, 8'hff);
    chk(16'(wake), 16'h0001);
    flg = 8'hff;
    for (i = 0; i < 13; i++) expq.push_back(ord[i]);
    wr(8'ha8, 8'haf);
    for (i = 0; i < 13; i++) take_one();
    quiet(20);
    $display("test vectors done");
    ack_dly <= 8'h03;
    svc_len <= 8'h28;
    hi = 8;
    wr(8'hb8, 8'h08);
    wr(8'ha8, 8'h8d);
    @(posedge clock);
    src <= 6'h03;
    expq = '{0, 3, 2, 1};
    take_one();
    repeat (2) @(posedge clock);
    src <= 6'h06;
    quiet(6);
    src <= 6'h0e;
    take_one();
    take_one();
    quiet(10);
    wr(8'ha8, 8'h02);
    quiet(10);
    wr(8'ha8, 8'h82);
    take_one();
    $display("test nesting done");
    wr(8'ha8, 8'h00);
    wr(8'he8, 8'h81);
    wr(8'he9, 8'h00);
    @(posedge clock);
    pins <= 8'h00;
    repeat (4) @(posedge clock);
    rdchk(8'hc0, 8'h81);
    chk(16'(wake), 16'h0001);
    wr(8'he8, 8'h00);
    repeat (4) @(posedge clock);
    chk(16'(wake), 16'h0000);
    $display("test polarity done");
    // Port input 7 high over input 0 low, both flagged
    hi = 32'h4000;
    flg = 8'h81;
    expq = '{14, 7};
    wr(8'hf8, 8'h80);
    wr(8'he8, 8'h81);
    wr(8'ha8, 8'h80);
    take_one();
    take_one();
    $display("test port priority done");
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    rdchk(8'hf8, 8'h00);
    rdchk(8'ha8, 8'h00);
    chk(16'(wake), 16'h0000);
    quiet(4);
    $display("test reset done");
    finish_test();
  end
endmodule // two_level_nested_interrupt_ctrl_tb

`default_nettype wire
